// ### shared/fan_mux_pkg.sv
/*
 * Constants, field layouts and carrier types for the fan behaviour mux and
 * duty control. Assumes the temperature front end delivers finished 8-bit
 * readings in the same format as the thresholds.
 */
package fan_mux_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_DUTY_FAN1 = 8'h30;
	localparam logic [7:0] ADDR_DUTY_FAN2 = 8'h31;
	localparam logic [7:0] ADDR_DUTY_FAN3 = 8'h32;
	localparam logic [7:0] ADDR_CFG_FAN1 = 8'h5c;
	localparam logic [7:0] ADDR_CFG_FAN2 = 8'h5d;
	localparam logic [7:0] ADDR_CFG_FAN3 = 8'h5e;
	localparam logic [7:0] ADDR_ACOUSTIC_ONE = 8'h62;

	// ==========================================================
	// Field positions and reset values
	localparam int BEHAVIOUR_SELECT_MSB = 7;
	localparam int BEHAVIOUR_SELECT_LSB = 5;
	localparam int INVERT_BIT = 4;
	localparam int ALT_BIT = 3;
	localparam int KEEP_FLOOR_LSB = 5;
	localparam logic [7:0] CFG_RESET = 8'h82;
	localparam logic [7:0] ACOUSTIC_RESET = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'hff;
	localparam logic [7:0] DUTY_FULL = 8'hff;
	localparam logic [7:0] DUTY_ZERO = 8'h00;
	localparam logic [7:0] OFFSET64 = 8'h40;

	// ==========================================================
	// Behaviour codes, primary table then alternate table
	localparam logic [2:0] B_REM1 = 3'h0;
	localparam logic [2:0] B_LOCAL = 3'h1;
	localparam logic [2:0] B_REM2 = 3'h2;
	localparam logic [2:0] B_FULL = 3'h3;
	localparam logic [2:0] B_OFF = 3'h4;
	localparam logic [2:0] B_MAX_LOC_REM2 = 3'h5;
	localparam logic [2:0] B_MAX_THREE = 3'h6;
	localparam logic [2:0] B_MANUAL = 3'h7;
	localparam logic [2:0] BA_CPU0 = 3'h0;
	localparam logic [2:0] BA_CPU3 = 3'h3;
	localparam logic [2:0] BA_FULL_A = 3'h4;
	localparam logic [2:0] BA_MAX_CPU = 3'h5;
	localparam logic [2:0] BA_FULL_B = 3'h6;
	localparam logic [2:0] BA_MAX_ALL = 3'h7;

	// ==========================================================
	// Thermal zones: three sensor channels, then four CPU readings
	localparam int NUM_ZONES = 7;
	localparam int NUM_SETTINGS = 4;
	localparam int Z_REM1 = 0;
	localparam int Z_LOCAL = 1;
	localparam int Z_REM2 = 2;
	localparam int Z_CPU0 = 3;
	localparam int S_CPU = 3;
	localparam logic [6:0] MASK_NONE = 7'h00;
	localparam logic [6:0] MASK_LOC_REM2 = 7'h06;
	localparam logic [6:0] MASK_THREE = 7'h07;
	localparam logic [6:0] MASK_CPU = 7'h78;
	localparam logic [6:0] MASK_ALL = 7'h7f;

	// Thermal settings of one channel.
	typedef struct packed {
		logic [7:0] fan_on_threshold;
		logic [7:0] off_hysteresis;
		logic [7:0] ramp_span;
		logic [7:0] overtemp_limit;
	} zone_cfg_t;

	// Duty limits of one fan output.
	typedef struct packed {
		logic [7:0] floor_duty;
		logic [7:0] max_duty;
		logic overtemp_to_full;
	} fan_limit_t;

	// Output mode after the behaviour decode.
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_FULL = 2'b11,
		MODE_MANUAL = 2'b10
	} fan_mode_t;

	// Spin-up sequence, Gray along idle, spin, run.
	typedef enum logic [1:0] {
		SPIN_IDLE = 2'b00,
		SPIN_KICK = 2'b01,
		SPIN_RUN = 2'b11
	} spin_state_t;

	// Maps a reading to signed degrees in either number format.
	function automatic logic signed [9:0] to_degrees(input logic [7:0] v, input logic off64);
		to_degrees = off64 ? $signed({2'b00, v}) - $signed({2'b00, OFFSET64})
			: $signed({{2{v[7]}}, v});
	endfunction

endpackage

// ### logic/zone_duty_curve.sv
/*
 * One thermal zone's duty curve for one fan output, with on/off hysteresis.
 * Assumes temperature and settings are stable for a cycle and on clk.
 */
`timescale 1ns/1ps

module zone_duty_curve (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Zone reading and settings
	input wire logic [7:0] temp,
	input wire logic off64,
	input wire fan_mux_pkg::zone_cfg_t cfg,
	input wire logic [7:0] floor_duty,
	// Result
	output logic zone_on,
	output logic [7:0] duty
);

	// ==========================================================
	// Arithmetic
	logic signed [9:0] t_deg;
	logic signed [9:0] thr_deg;
	logic signed [9:0] off_deg;
	logic signed [9:0] excess;
	logic [7:0] span;
	logic [15:0] scaled;
	logic [15:0] slope;
	logic on_r;
	logic on_nxt;
	logic [7:0] duty_r;
	logic [7:0] duty_nxt;

	// A zero span would divide by zero, so it is read as one degree.
	assign t_deg = fan_mux_pkg::to_degrees(temp, off64);
	assign thr_deg = fan_mux_pkg::to_degrees(cfg.fan_on_threshold, off64);
	assign off_deg = thr_deg - $signed({2'b00, cfg.off_hysteresis});
	assign excess = t_deg - thr_deg;
	assign span = (cfg.ramp_span == 8'h00) ? 8'h01 : cfg.ramp_span;
	assign scaled = 16'(fan_mux_pkg::DUTY_FULL - floor_duty) * 16'(excess[7:0]);
	assign slope = scaled / 16'(span);

	assign on_nxt = (t_deg > thr_deg) ? 1'b1 : ((t_deg < off_deg) ? 1'b0 : on_r);

	assign duty_nxt = !on_nxt ? fan_mux_pkg::DUTY_ZERO
		: (excess <= 10'sd0) ? floor_duty
		: (excess >= $signed({2'b00, span})) ? fan_mux_pkg::DUTY_FULL
		: 8'(16'(floor_duty) + slope);

	// State and result registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_r <= 1'b0;
			duty_r <= 8'h00;
		end else begin
			on_r <= on_nxt;
			duty_r <= duty_nxt;
		end
	end

	assign zone_on = on_r;
	assign duty = duty_r;

endmodule

// ### logic/fan_source_mux.sv
/*
 * Fan behaviour mux and duty control for three fan outputs: source select,
 * fastest-speed combine, manual mode with overtemperature boost, spin-up and
 * keep-at-floor, with the duty and configuration registers.
 * Assumes a register access port already decoded from the serial host bus,
 * readings already converted, and speed pulse pins asynchronous to clk.
 */
`timescale 1ns/1ps

module fan_source_mux #(
	parameter int NUM_FANS = 3,
	parameter int SPIN_EDGES = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Thermal readings and settings
	input wire logic [fan_mux_pkg::NUM_ZONES-1:0][7:0] zone_temp,
	input wire fan_mux_pkg::zone_cfg_t [fan_mux_pkg::NUM_SETTINGS-1:0] zone_cfg,
	input wire logic offset64_format,
	// Per-fan limits
	input wire fan_mux_pkg::fan_limit_t [NUM_FANS-1:0] fan_limit,
	// Fan pins
	input wire logic [NUM_FANS-1:0] speed_pulse_input,
	output logic [NUM_FANS-1:0] pwm_out,
	output logic [NUM_FANS-1:0][7:0] fan_duty
);

	// ==========================================================
	// Elaboration checks
	if (NUM_FANS != 3) begin : g_bad_fans
		$error("fan_source_mux serves exactly three fan outputs");
	end
	if (SPIN_EDGES < 1 || SPIN_EDGES > 3) begin : g_bad_edges
		$error("fan_source_mux spin-up edge count must be 1 to 3");
	end

	// ==========================================================
	// Functions

	// Zones feeding a fan for a behaviour code; empty for non-thermal codes.
	function automatic logic [6:0] zone_mask(input logic [2:0] code, input logic alternate_table_select);
		zone_mask = fan_mux_pkg::MASK_NONE;
		if (!alternate_table_select) begin
			case (code)
				fan_mux_pkg::B_REM1: zone_mask = 7'(1 << fan_mux_pkg::Z_REM1);
				fan_mux_pkg::B_LOCAL: zone_mask = 7'(1 << fan_mux_pkg::Z_LOCAL);
				fan_mux_pkg::B_REM2: zone_mask = 7'(1 << fan_mux_pkg::Z_REM2);
				fan_mux_pkg::B_MAX_LOC_REM2: zone_mask = fan_mux_pkg::MASK_LOC_REM2;
				fan_mux_pkg::B_MAX_THREE: zone_mask = fan_mux_pkg::MASK_THREE;
				default: zone_mask = fan_mux_pkg::MASK_NONE;
			endcase
		end else begin
			case (code)
				fan_mux_pkg::BA_MAX_CPU: zone_mask = fan_mux_pkg::MASK_CPU;
				fan_mux_pkg::BA_MAX_ALL: zone_mask = fan_mux_pkg::MASK_ALL;
				default: begin
					if (code <= fan_mux_pkg::BA_CPU3) begin
						zone_mask = 7'(1 << (fan_mux_pkg::Z_CPU0 + int'(code)));
					end
				end
			endcase
		end
	endfunction

	// Output mode for a behaviour code.
	function automatic fan_mux_pkg::fan_mode_t decode_mode(input logic [2:0] code,
			input logic alternate_table_select);
		decode_mode = fan_mux_pkg::MODE_AUTO;
		if (!alternate_table_select) begin
			case (code)
				fan_mux_pkg::B_FULL: decode_mode = fan_mux_pkg::MODE_FULL;
				fan_mux_pkg::B_OFF: decode_mode = fan_mux_pkg::MODE_OFF;
				fan_mux_pkg::B_MANUAL: decode_mode = fan_mux_pkg::MODE_MANUAL;
				default: decode_mode = fan_mux_pkg::MODE_AUTO;
			endcase
		end else begin
			case (code)
				fan_mux_pkg::BA_FULL_A: decode_mode = fan_mux_pkg::MODE_FULL;
				fan_mux_pkg::BA_FULL_B: decode_mode = fan_mux_pkg::MODE_FULL;
				default: decode_mode = fan_mux_pkg::MODE_AUTO;
			endcase
		end
	endfunction

	// Settings slot shared by a zone; the four CPU readings share one.
	function automatic int settings_of(input int zone);
		settings_of = (zone >= fan_mux_pkg::Z_CPU0) ? fan_mux_pkg::S_CPU : zone;
	endfunction

	// ==========================================================
	// Registers
	logic [NUM_FANS-1:0][7:0] cfg_r;
	logic [7:0] acoustic_r;
	logic [NUM_FANS-1:0][7:0] manual_duty_r;
	logic [NUM_FANS-1:0][7:0] duty_r;
	logic [NUM_FANS-1:0][7:0] duty_nxt;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic [7:0] rdata_nxt;
	logic [NUM_FANS-1:0] hit_cfg;
	logic [NUM_FANS-1:0] hit_duty;
	logic hit_acoustic;
	logic [7:0] pwm_cnt_r;
	logic overtemp;
	logic [fan_mux_pkg::NUM_ZONES-1:0] zone_hot;

	// Address decode for the register port.
	assign hit_acoustic = (reg_addr == fan_mux_pkg::ADDR_ACOUSTIC_ONE);
	assign hit_cfg[0] = (reg_addr == fan_mux_pkg::ADDR_CFG_FAN1);
	assign hit_cfg[1] = (reg_addr == fan_mux_pkg::ADDR_CFG_FAN2);
	assign hit_cfg[2] = (reg_addr == fan_mux_pkg::ADDR_CFG_FAN3);
	assign hit_duty[0] = (reg_addr == fan_mux_pkg::ADDR_DUTY_FAN1);
	assign hit_duty[1] = (reg_addr == fan_mux_pkg::ADDR_DUTY_FAN2);
	assign hit_duty[2] = (reg_addr == fan_mux_pkg::ADDR_DUTY_FAN3);

	// duty read shows applied duty
	// Unmapped addresses read as zero.
	assign rdata_nxt = hit_acoustic ? acoustic_r
		: |hit_cfg ? cfg_r[hit_cfg[2] ? 2 : (hit_cfg[1] ? 1 : 0)]
		: |hit_duty ? duty_r[hit_duty[2] ? 2 : (hit_duty[1] ? 1 : 0)]
		: 8'h00;

	// Read data is captured one edge after the read strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= reg_rd ? rdata_nxt : rdata_r;
			rvalid_r <= reg_rd;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acoustic_r <= fan_mux_pkg::ACOUSTIC_RESET;
		end else if (reg_wr && hit_acoustic) begin
			acoustic_r <= reg_wdata;
		end
	end

	// Free-running PWM period counter shared by all outputs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_cnt_r <= 8'h00;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
		end
	end

	for (genvar z = 0; z < fan_mux_pkg::NUM_ZONES; z++) begin : g_hot
		assign zone_hot[z] = fan_mux_pkg::to_degrees(zone_temp[z], offset64_format) >
			fan_mux_pkg::to_degrees(zone_cfg[settings_of(z)].overtemp_limit, offset64_format);
	end
	assign overtemp = |zone_hot;

	// ==========================================================
	// Per-fan datapath
	for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
		logic [fan_mux_pkg::NUM_ZONES-1:0][7:0] zduty;
		logic [fan_mux_pkg::NUM_ZONES-1:0] zon;
		logic [6:0] mask;
		fan_mux_pkg::fan_mode_t mode;
		logic [7:0] best;
		logic any_on;
		logic keep_floor;
		logic [7:0] auto_duty;
		logic [7:0] target;
		logic [2:0] sync_r;
		logic level_r;
		logic rise;
		logic [1:0] edges_r;
		fan_mux_pkg::spin_state_t spin_r;
		fan_mux_pkg::spin_state_t spin_nxt;

		for (genvar z = 0; z < fan_mux_pkg::NUM_ZONES; z++) begin : g_zone
			zone_duty_curve u_curve (
				.clk(clk),
				.rst_n(rst_n),
				.temp(zone_temp[z]),
				.off64(offset64_format),
				.cfg(zone_cfg[settings_of(z)]),
				.floor_duty(fan_limit[f].floor_duty),
				.zone_on(zon[z]),
				.duty(zduty[z])
			);
		end

		assign mask = zone_mask(cfg_r[f][fan_mux_pkg::BEHAVIOUR_SELECT_MSB:fan_mux_pkg::BEHAVIOUR_SELECT_LSB],
			cfg_r[f][fan_mux_pkg::ALT_BIT]);
		assign mode = decode_mode(cfg_r[f][fan_mux_pkg::BEHAVIOUR_SELECT_MSB:fan_mux_pkg::BEHAVIOUR_SELECT_LSB],
			cfg_r[f][fan_mux_pkg::ALT_BIT]);

		always_comb begin
			best = fan_mux_pkg::DUTY_ZERO;
			for (int z = 0; z < fan_mux_pkg::NUM_ZONES; z++) begin
				if (mask[z] && zduty[z] > best) begin
					best = zduty[z];
				end
			end
		end
		assign any_on = |(zon & mask);

		assign keep_floor = acoustic_r[fan_mux_pkg::KEEP_FLOOR_LSB + f];

		// Automatic duty is clamped to the fan's configured maximum, except the kept floor duty, which is not clamped.
		assign auto_duty = !any_on ? (keep_floor ? fan_limit[f].floor_duty : best)
			: (best > fan_limit[f].max_duty) ? fan_limit[f].max_duty : best;

		assign target = (mode == fan_mux_pkg::MODE_FULL) ? fan_mux_pkg::DUTY_FULL
			: (mode == fan_mux_pkg::MODE_OFF) ? fan_mux_pkg::DUTY_ZERO
			: (mode == fan_mux_pkg::MODE_MANUAL) ? (overtemp
				? (fan_limit[f].overtemp_to_full ? fan_mux_pkg::DUTY_FULL
					: fan_limit[f].max_duty)
				: manual_duty_r[f])
			: auto_duty;

		// Speed pulse: three stages, a rising change counts when stages two and three agree.
		assign rise = (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;

		// spin-up sequence
		// Manual mode bypasses spin-up so software sees its duty at once.
		always_comb begin
			spin_nxt = spin_r;
			case (spin_r)
				fan_mux_pkg::SPIN_IDLE: begin
					if (target != fan_mux_pkg::DUTY_ZERO) begin
						spin_nxt = (mode == fan_mux_pkg::MODE_MANUAL) ?
							fan_mux_pkg::SPIN_RUN : fan_mux_pkg::SPIN_KICK;
					end
				end
				fan_mux_pkg::SPIN_KICK: begin
					if (target == fan_mux_pkg::DUTY_ZERO) begin
						spin_nxt = fan_mux_pkg::SPIN_IDLE;
					end else if (mode == fan_mux_pkg::MODE_MANUAL ||
							(rise && 32'(edges_r) == SPIN_EDGES - 1)) begin
						spin_nxt = fan_mux_pkg::SPIN_RUN;
					end
				end
				fan_mux_pkg::SPIN_RUN: begin
					if (target == fan_mux_pkg::DUTY_ZERO) begin
						spin_nxt = fan_mux_pkg::SPIN_IDLE;
					end
				end
				default: spin_nxt = fan_mux_pkg::SPIN_IDLE;
			endcase
		end

		assign duty_nxt[f] = (spin_nxt == fan_mux_pkg::SPIN_KICK) ? fan_mux_pkg::DUTY_FULL
			: (spin_nxt == fan_mux_pkg::SPIN_IDLE) ? fan_mux_pkg::DUTY_ZERO : target;

		// Pin synchroniser and spin state.
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sync_r <= 3'b000;
				level_r <= 1'b0;
				edges_r <= 2'b00;
				spin_r <= fan_mux_pkg::SPIN_IDLE;
			end else begin
				sync_r <= {sync_r[1:0], speed_pulse_input[f]};
				level_r <= (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
				edges_r <= (spin_r != fan_mux_pkg::SPIN_KICK) ? 2'b00 : edges_r + 2'(rise);
				spin_r <= spin_nxt;
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cfg_r[f] <= fan_mux_pkg::CFG_RESET;
				manual_duty_r[f] <= fan_mux_pkg::DUTY_RESET;
				duty_r[f] <= fan_mux_pkg::DUTY_ZERO;
			end else begin
				cfg_r[f] <= (reg_wr && hit_cfg[f]) ? reg_wdata : cfg_r[f];
				if (reg_wr && hit_duty[f] && mode == fan_mux_pkg::MODE_MANUAL) begin
					manual_duty_r[f] <= reg_wdata;
				end
				duty_r[f] <= duty_nxt[f];
			end
		end

		// Full duty holds the pin solid; bit 4 inverts the active level.
		assign pwm_out[f] = ((duty_r[f] == fan_mux_pkg::DUTY_FULL) || (pwm_cnt_r < duty_r[f]))
			^ cfg_r[f][fan_mux_pkg::INVERT_BIT];
		assign fan_duty[f] = duty_r[f];
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

endmodule

// ### sim/fan_mux_monitor.sv
/* Port checker for the fan behaviour mux.
   Assumes it is bound to fan_source_mux and sees only its ports. */
`timescale 1ns/1ps

// ==========================================
// Checker
module fan_mux_monitor #(
	parameter int NUM_FANS = 3,
	parameter int SPIN_EDGES = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Thermal inputs and limits
	input wire logic [fan_mux_pkg::NUM_ZONES-1:0][7:0] zone_temp,
	input wire fan_mux_pkg::zone_cfg_t [fan_mux_pkg::NUM_SETTINGS-1:0] zone_cfg,
	input wire logic offset64_format,
	input wire fan_mux_pkg::fan_limit_t [NUM_FANS-1:0] fan_limit,
	// Applied duty and fan pins
	input wire logic [NUM_FANS-1:0][7:0] fan_duty,
	input wire logic [NUM_FANS-1:0] pwm_out
);
	logic [7:0] cfg_sh [3];
	logic [7:0] ac_sh;
	logic [7:0] exp_rd;
	logic hot;
	wire logic [2:0] b0 = cfg_sh[0][7:5];
	wire logic alt0 = cfg_sh[0][3];
	wire logic man0 = !alt0 && b0 == 3'h7;
	wire logic off0 = !alt0 && b0 == 3'h4;
	wire logic full0 = alt0 ? (b0 == 3'h4 || b0 == 3'h6) : b0 == 3'h3;

	// Shadow of the writable settings, so reads can be predicted.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_sh <= '{3{8'h82}};
			ac_sh <= 8'h00;
		end else if (reg_wr && reg_addr inside {8'h5c, 8'h5d, 8'h5e}) begin
			cfg_sh[reg_addr[1:0]] <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h62) begin
			ac_sh <= reg_wdata;
		end
	end

	// Expected read data; duty registers show the applied duty.
	always_comb begin
		case (reg_addr)
			8'h30, 8'h31, 8'h32: exp_rd = fan_duty[reg_addr[1:0]];
			8'h5c, 8'h5d, 8'h5e: exp_rd = cfg_sh[reg_addr[1:0]];
			8'h62: exp_rd = ac_sh;
			default: exp_rd = 8'h00;
		endcase
	end

	// Any zone above its limit; offset 64 orders as unsigned.
	always_comb begin
		hot = 1'b0;
		for (int z = 0; z < 7; z++) begin
			if (offset64_format ? zone_temp[z] > zone_cfg[(z < 3) ? z : 3].overtemp_limit
				: $signed(zone_temp[z]) > $signed(zone_cfg[(z < 3) ? z : 3].overtemp_limit)) begin
				hot = 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_rvalid_pulse: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe gave no valid pulse");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("valid pulse without a read");
	chk_read_data: assert property (reg_rd |=> reg_rdata == $past(exp_rd))
		else $error("read data differs from register contents");
	chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_manual_write: assert property (man0 && !hot && reg_wr && reg_addr == 8'h30
		##1 (man0 && !hot)[*2] |-> fan_duty[0] == $past(reg_wdata, 2))
		else $error("manual duty not applied");
	chk_overtemp_boost: assert property ((man0 && hot && $stable(fan_limit[0]))[*3]
		|-> fan_duty[0] == (fan_limit[0].overtemp_to_full ? 8'hff : fan_limit[0].max_duty))
		else $error("overtemperature did not boost manual fan");
	chk_full_mode: assert property (full0[*3] |-> fan_duty[0] == 8'hff)
		else $error("full speed code not at full duty");
	chk_off_mode: assert property (off0[*3] |-> fan_duty[0] == 8'h00)
		else $error("disabled code not at zero duty");
	chk_pin_full: assert property (fan_duty[0] == 8'hff |-> pwm_out[0] == !cfg_sh[0][4])
		else $error("full duty pin not at active level");
	chk_pin_zero: assert property (fan_duty[0] == 8'h00 |-> pwm_out[0] == cfg_sh[0][4])
		else $error("zero duty pin not at idle level");

	// Main scenarios reached.
	cov_manual_hot: cover property (man0 && hot);
	cov_alt_full: cover property (full0 && alt0);
	cov_acoustic_read: cover property (reg_rd && reg_addr == 8'h62);
endmodule

bind fan_source_mux fan_mux_monitor #(.NUM_FANS(NUM_FANS), .SPIN_EDGES(SPIN_EDGES)) i_fan_mux_monitor (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.zone_temp(zone_temp), .zone_cfg(zone_cfg), .offset64_format(offset64_format),
	.fan_limit(fan_limit), .fan_duty(fan_duty), .pwm_out(pwm_out)
);

// ### sim/fan_speed_pulse_input_model.sv
/* Behavioural fans with speed pulse outputs.
   Assumes non-inverted drive: a high level turns the rotor. */
`timescale 1ns/1ps

// ==========================================
// Fan model
module fan_speed_pulse_input_model #(
	parameter int NUM_FANS = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Drive and test control
	input wire logic [NUM_FANS-1:0] pwm_out,
	input wire logic [NUM_FANS-1:0] stall,
	// Open-drain speed lines with pull-up
	output logic [NUM_FANS-1:0] speed_pulse_input
);
	logic [NUM_FANS-1:0][4:0] turn_r;

	// The rotor advances only while driven, so a slow duty gives slow pulses.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			turn_r <= '0;
		end else begin
			for (int i = 0; i < NUM_FANS; i++) begin
				if (pwm_out[i] && !stall[i]) begin
					turn_r[i] <= turn_r[i] + 5'h01;
				end
			end
		end
	end

	// A stalled fan releases its line, which the pull-up holds high.
	always_comb begin
		for (int i = 0; i < NUM_FANS; i++) begin
			speed_pulse_input[i] = stall[i] | turn_r[i][4];
		end
	end
endmodule

// ### sim/fan_source_mux_tb.sv
/* Self-checking bench for the fan behaviour mux.
   Assumes the fan model and the bound checker are compiled with it. */
`timescale 1ns/1ps

// ==========================================
// Bench
module fan_source_mux_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [6:0][7:0] zone_temp = '0;
	fan_mux_pkg::zone_cfg_t [3:0] zone_cfg = {4{32'h28041464}};
	logic offset64_format = 1'b0;
	fan_mux_pkg::fan_limit_t [2:0] fan_limit = {3{8'h40, 8'hc0, 1'b0}};
	logic [2:0] stall = 3'h0;
	logic [2:0] spd;
	logic [2:0] pwm_out;
	logic [2:0][7:0] fan_duty;
	int err_count = 0;
	int total_checks = 0;

	// 10 MHz clock.
	always #50 clk = ~clk;

	fan_source_mux i_fan_source_mux (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.zone_temp(zone_temp), .zone_cfg(zone_cfg), .offset64_format(offset64_format),
		.fan_limit(fan_limit), .speed_pulse_input(spd), .pwm_out(pwm_out), .fan_duty(fan_duty)
	);
	fan_speed_pulse_input_model i_fan_speed_pulse_input_model (
		.clk(clk), .rst_n(rst_n), .pwm_out(pwm_out), .stall(stall), .speed_pulse_input(spd)
	);

	// ==========================================
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data lands one edge after the strobe; sample just past it.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("read valid", {7'h00, reg_rvalid}, 8'h01);
		check("read data", reg_rdata, exp);
	endtask

	// Spin-up length depends on the fan, so settle under a bound.
	task automatic wait_duty(input int f, input logic [7:0] exp);
		int n;
		n = 0;
		#1;
		while (fan_duty[f] !== exp && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("fan duty", fan_duty[f], exp);
		if (n >= 3000) begin
			end_sim();
		end
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] adr [8] = '{8'h5c, 8'h5d, 8'h5e, 8'h62, 8'h30, 8'h31, 8'h32, 8'h40};
		logic [7:0] val [8] = '{8'h82, 8'h82, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wr(8'h40, 8'h5a);
		for (int i = 0; i < 8; i++) begin
			rd(adr[i], val[i]);
		end
		$display("test reset done");
	endtask

	task automatic t_modes();
		wr(8'h5c, 8'h60);
		wr(8'h5e, 8'h88);
		wait_duty(0, 8'hff);
		check("fan1 pin", {7'h00, pwm_out[0]}, 8'h01);
		wr(8'h5c, 8'h70);
		#1;
		check("fan1 pin inverted", {7'h00, pwm_out[0]}, 8'h00);
		wait_duty(2, 8'hff);
		check("fan2 duty", fan_duty[1], 8'h00);
		wr(8'h5e, 8'h80);
		wait_duty(2, 8'h00);
		wr(8'h5e, 8'hc8);
		wait_duty(2, 8'hff);
		rd(8'h5e, 8'hc8);
		$display("test modes done");
	endtask

	task automatic t_manual();
		wr(8'h5c, 8'he0);
		wr(8'h30, 8'h40);
		wait_duty(0, 8'h40);
		rd(8'h30, 8'h40);
		wr(8'h31, 8'h55);
		rd(8'h31, 8'h00);
		wr(8'h5d, 8'he0);
		wait_duty(1, 8'hff);
		@(posedge clk);
		zone_temp[1] <= 8'h70;
		wait_duty(0, 8'hc0);
		@(posedge clk);
		fan_limit[0].overtemp_to_full <= 1'b1;
		wait_duty(0, 8'hff);
		@(posedge clk);
		zone_temp[1] <= 8'h00;
		wait_duty(0, 8'h40);
		$display("test manual done");
	endtask

	task automatic t_auto();
		@(posedge clk);
		fan_limit[0] <= {8'h40, 8'hff, 1'b0};
		stall[0] <= 1'b1;
		wr(8'h5c, 8'h00);
		wait_duty(0, 8'h00);
		@(posedge clk);
		zone_temp[0] <= 8'h32;
		repeat (500) @(posedge clk);
		#1;
		check("spin duty", fan_duty[0], 8'hff);
		stall[0] <= 1'b0;
		wait_duty(0, 8'h9f);
		@(posedge clk);
		zone_temp[0] <= 8'h26;
		wait_duty(0, 8'h40);
		@(posedge clk);
		zone_temp[0] <= 8'h23;
		wait_duty(0, 8'h00);
		wr(8'h62, 8'h20);
		wait_duty(0, 8'h40);
		rd(8'h62, 8'h20);
		wr(8'h62, 8'hc0);
		wait_duty(0, 8'h00);
		$display("test auto done");
	endtask

	task automatic t_mux();
		logic [7:0] cf [11] = '{8'h00, 8'h20, 8'h40, 8'ha0, 8'hc0, 8'h08, 8'ha8, 8'h28,
			8'h48, 8'h68, 8'he8};
		logic [7:0] ex [11] = '{8'hcc, 8'h99, 8'h66, 8'h99, 8'hcc, 8'h19, 8'hb2, 8'h4c,
			8'h7f, 8'hb2, 8'hcc};
		@(posedge clk);
		fan_limit[0] <= {8'h00, 8'hff, 1'b0};
		zone_temp <= {8'h36, 8'h32, 8'h2e, 8'h2a, 8'h30, 8'h34, 8'h38};
		for (int i = 0; i < 11; i++) begin
			wr(8'h5c, cf[i]);
			wait_duty(0, ex[i]);
		end
		wr(8'h5c, 8'h08);
		wait_duty(0, 8'h19);
		@(posedge clk);
		offset64_format <= 1'b1;
		zone_cfg[0].fan_on_threshold <= 8'h70;
		zone_temp[0] <= 8'h80;
		wr(8'h5c, 8'h00);
		wait_duty(0, 8'hcc);
		$display("test mux done");
	endtask

	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_manual();
		t_auto();
		t_mux();
		end_sim();
	end
endmodule
